/* File: inc/ipfg_pkg.sv */
/*
 holds register offset, field positions, reset value and types for the
 priority field group register block.
 assumes a 32-bit avalon-mm slave bus and a single 50 mhz clock.
*/
package ipfg_pkg;
   localparam int          ADDR_W         = 4;
   localparam int          DATA_W         = 32;
   localparam int          REG_W          = 16;
   localparam int          PRIO_W         = 3;
   localparam int          NSRC           = 4;
   localparam logic [3:0]  PRIO_OFFSET    = 4'h0;
   localparam logic [3:0]  LEVEL_OFFSET   = 4'h4;
   localparam logic [3:0]  REQ_OFFSET     = 4'h8;
   localparam int          TMR4_LSB       = 12;
   localparam int          CMP4_LSB       = 8;
   localparam int          CMP3_LSB       = 4;
   localparam int          XFR2_LSB       = 0;
   localparam logic [15:0] PRIO_RESET     = 16'h4444;
   localparam logic [15:0] PRIO_WMASK     = 16'h7777;
   localparam logic [2:0]  PRIO_OFF       = 3'h0;
   localparam logic [2:0]  PRIO_MAX       = 3'h7;
   localparam logic [31:0] UNMAPPED_DATA  = 32'h0;

   typedef struct packed {
      logic [2:0] timer_four_prio;
      logic [2:0] compare_ch4_prio;
      logic [2:0] compare_ch3_prio;
      logic [2:0] xfer_ch2_done_prio;
   } ipfg_prio_t;

   typedef struct packed {
      logic             read;
      logic             write;
      logic [3:0]       address;
      logic [31:0]      writedata;
      logic [3:0]       byteenable;
   } ipfg_avreq_t;
endpackage

/* File: rtl/ipfg_level_map.sv */
/*
 maps one 3-bit priority code and its request to a level and a gated request.
 assumes code and request arrive from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module ipfg_level_map (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [2:0] code,
   input  wire logic       req,
   output logic      [2:0] level,
   output logic            active
);
   // registered level and gated request
   always_ff @(posedge clk) begin
      if (!rstn) begin
         level  <= 3'h0;
         active <= 1'b0;
      end else begin
         level  <= code;                                 // [R1] [R2]
         active <= req && (code != ipfg_pkg::PRIO_OFF);   // [R3]
      end
   end

   off_blocks_a : assert property (@(posedge clk) disable iff (!rstn) // [R3]
      code == ipfg_pkg::PRIO_OFF |=> !active)
      else $error("disabled source gave an active request");
endmodule
`default_nettype wire

/* File: rtl/ipfg_top.sv */
/*
 holds the four-field interrupt priority register, its avalon-mm slave and
 the per-source level and request outputs.
 assumes requests come from same-clock logic and a bus master that holds
 its request until waitrequest is low.
*/
// The Avalon-MM register port and the register offsets are this design's own decisions.
// Function
// R1 - a field holding 111 gives its source level 7, the highest level.
// R2 - a field holding 001 gives level 1, with codes between mapping linearly.
// R3 - a field holding 000 disables its source so its request is never passed on.
// R4 - bits 14 to 12 hold the timer four priority.
// R5 - bits 10 to 8 hold the compare channel four priority.
// R6 - bits 6 to 4 hold the compare channel three priority.
// R7 - bits 2 to 0 hold the transfer channel two priority; bits 15, 11, 7, 3 read zero.
`timescale 1ns/10ps
`default_nettype none
module ipfg_top (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [3:0]  src_req,
   output logic      [11:0] src_level,
   output logic      [3:0]  src_active,
   output ipfg_pkg::ipfg_prio_t prio_fields
);
   logic [15:0] prio_q;
   logic        ack_q;
   logic [31:0] rdata_q;
   logic        access;
   logic [15:0] wdata_d;

   // one wait cycle then acknowledge
   assign access          = avs_read || avs_write;
   assign avs_waitrequest = access && !ack_q;
   assign avs_readdata    = rdata_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access && !ack_q;
      end
   end

   // byte-lane merge with unimplemented bits forced low
   always_comb begin
      wdata_d = prio_q;
      if (avs_byteenable[0]) begin
         wdata_d[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
         wdata_d[15:8] = avs_writedata[15:8];
      end
      wdata_d = wdata_d & ipfg_pkg::PRIO_WMASK; // [R7]
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         prio_q <= ipfg_pkg::PRIO_RESET;
      end else if (avs_write && ack_q && avs_address == ipfg_pkg::PRIO_OFFSET) begin
         prio_q <= wdata_d; // [R4] [R5] [R6] [R7]
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= 32'h0;
      end else if (avs_read && !ack_q) begin
         if (avs_address == ipfg_pkg::PRIO_OFFSET) begin
            rdata_q <= {16'h0, prio_q & ipfg_pkg::PRIO_WMASK}; // [R7]
         end else if (avs_address == ipfg_pkg::LEVEL_OFFSET) begin
            rdata_q <= {20'h0, src_level};
         end else if (avs_address == ipfg_pkg::REQ_OFFSET) begin
            rdata_q <= {28'h0, src_active};
         end else begin
            rdata_q <= ipfg_pkg::UNMAPPED_DATA;
         end
      end
   end

   // field extraction
   assign prio_fields.timer_four_prio    = prio_q[ipfg_pkg::TMR4_LSB +: 3]; // [R4]
   assign prio_fields.compare_ch4_prio   = prio_q[ipfg_pkg::CMP4_LSB +: 3]; // [R5]
   assign prio_fields.compare_ch3_prio   = prio_q[ipfg_pkg::CMP3_LSB +: 3]; // [R6]
   assign prio_fields.xfer_ch2_done_prio = prio_q[ipfg_pkg::XFR2_LSB +: 3]; // [R7]

   // source 0 is transfer ch2, 1 compare ch3, 2 compare ch4, 3 timer four
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_src
         ipfg_level_map u_map (
            .clk    (clk),
            .rstn   (rstn),
            .code   (prio_q[gi*4 +: 3]),
            .req    (src_req[gi]),
            .level  (src_level[gi*3 +: 3]),
            .active (src_active[gi])
         );
      end
   endgenerate

   max_level_a : assert property (@(posedge clk) disable iff (!rstn) // [R1]
      prio_q[14:12] == ipfg_pkg::PRIO_MAX |=> src_level[11:9] == 3'h7)
      else $error("code 111 did not give level 7");
   min_level_a : assert property (@(posedge clk) disable iff (!rstn) // [R2]
      prio_q[2:0] == 3'h1 |=> src_level[2:0] == 3'h1)
      else $error("code 001 did not give level 1");
   cmp4_req_a : assert property (@(posedge clk) disable iff (!rstn) // [R3]
      1'b1 |=> src_active[2] == $past(src_req[2] && prio_q[10:8] != 3'h0))
      else $error("compare ch4 request gating wrong");
   tmr4_field_a : assert property (@(posedge clk) disable iff (!rstn) // [R4]
      (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[1])
      |=> prio_fields.timer_four_prio == $past(avs_writedata[14:12]))
      else $error("timer four field misplaced");
   unimpl_zero_a : assert property (@(posedge clk) disable iff (!rstn) // [R7]
      (prio_q & 16'h8888) == 16'h0)
      else $error("unimplemented bits set");
   wr_update_a : assert property (@(posedge clk) disable iff (!rstn) // [R5] [R6]
      (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable == 4'hF)
      |=> prio_q == ($past(avs_writedata[15:0]) & 16'h7777))
      else $error("full write did not land in register");
   wait_one_a : assert property (@(posedge clk) disable iff (!rstn)
      (access && avs_waitrequest) |=> (!access || !avs_waitrequest))
      else $error("waitrequest held beyond one cycle");
   rd_zero_a : assert property (@(posedge clk) disable iff (!rstn) // [R7]
      (avs_read && avs_waitrequest && avs_address == 4'h0) |=> rdata_q[31:15] == 17'h0)
      else $error("read of upper bits not zero");

   cov_write_c : cover property (@(posedge clk) disable iff (!rstn)
      avs_write && !avs_waitrequest);
   cov_read_c  : cover property (@(posedge clk) disable iff (!rstn)
      avs_read && !avs_waitrequest);
   cov_off_c   : cover property (@(posedge clk) disable iff (!rstn)
      src_req[3] && prio_q[14:12] == 3'h0);
endmodule
`default_nettype wire

/* File: bench/irq_priority_field_group_bench.sv */
/*
 self-checking bench for the priority field group register block.
 assumes the one-wait-cycle avalon-mm slave and one-cycle output latency.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_priority_field_group_bench;
   logic        clk, rstn, avs_read, avs_write, avs_waitrequest;
   logic [3:0]  avs_address, avs_byteenable, src_req, src_active;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [11:0] src_level;
   ipfg_pkg::ipfg_prio_t prio_fields;
   int          num_errors, n_compared;
   ipfg_top DUT (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_req(src_req),
      .src_level(src_level), .src_active(src_active), .prio_fields(prio_fields));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic conclude;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one bus access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         num_errors++;
         conclude();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic t_reset;
      bus(1'b0, 4'h0, 32'h0, 4'hF, rd);
      chk(rd, 32'h0000_4444);
      chk({20'h0, prio_fields}, 32'h0000_0924);
      bus(1'b0, 4'hC, 32'h0, 4'hF, rd);
      chk(rd, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_fields;
      bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF, rd);
      bus(1'b0, 4'h0, 32'h0, 4'hF, rd);
      chk(rd, 32'h0000_7777);
      bus(1'b1, 4'h0, 32'h0000_7531, 4'hF, rd);
      settle();
      chk({20'h0, prio_fields}, {20'h0, 3'h7, 3'h5, 3'h3, 3'h1});
      chk({20'h0, src_level}, {20'h0, 3'h7, 3'h5, 3'h3, 3'h1});
      bus(1'b1, 4'h4, 32'h0, 4'hF, rd);
      bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'h1, rd);
      bus(1'b0, 4'h0, 32'h0, 4'hF, rd);
      chk(rd, 32'h0000_7577);
      $display("field test done");
   endtask
   task automatic t_codes;
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         bus(1'b1, 4'h0, {16'h0, 1'b0, c, 1'b0, c, 1'b0, c, 1'b0, c}, 4'hF, rd);
         settle();
         chk({20'h0, src_level}, {20'h0, c, c, c, c});
         chk({28'h0, src_active}, {28'h0, {4{c != 3'h0}}});
      end
      bus(1'b1, 4'h0, 32'h0000_0530, 4'hF, rd);
      settle();
      chk({28'h0, src_active}, 32'h6);
      @(posedge clk);
      src_req <= 4'h5;
      settle();
      chk({28'h0, src_active}, 32'h4);
      $display("code test done");
   endtask
   initial begin
      rstn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      src_req = 4'hF;
      num_errors = 0;
      n_compared = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_fields();
      t_codes();
      conclude();
   end
endmodule
`default_nettype wire
